/* File: logic/rdt_consts.vh */
`ifndef RDT_CONSTS_VH
`define RDT_CONSTS_VH
// Register word addresses (word index, one per 32-bit register)
`define RDT_ADDR_W 4
`define RDT_OFF_COUNT 4'h0
`define RDT_OFF_RUN 4'h1
`define RDT_OFF_MODE 4'h2
`define RDT_OFF_PRESC 4'h3
`define RDT_OFF_STAT 4'h4
`define RDT_OFF_MASK 4'h5
// Mode register fields
`define RDT_MODE_LO 0
`define RDT_MODE_HI 1
`define RDT_MODE_PULSE 2
`define RDT_MODE_GATE 3
`define RDT_MODE_GPOL 4
`define RDT_MODE_SRC_LO 6
`define RDT_MODE_SRC_HI 7
`define RDT_MODE_W 8
`define RDT_MODE_TIMER 2'h0
// Count source select codes
`define RDT_SRC_UNDIV 2'h0
`define RDT_SRC_DIV8 2'h1
`define RDT_SRC_PROG 2'h2
`define RDT_SRC_SUB 2'h3
// Reset values and divider constants
`define RDT_RST_COUNT 16'hFFFF
`define RDT_RST_MODE 8'h00
`define RDT_RST_PRESC 8'h00
`define RDT_DIV8_LAST 3'h7
`define RDT_SUB_DIV 10'h1F3
`define RDT_SUB_LAST 5'h1F
`endif

/* File: logic/rdt_divider.v */
`timescale 1ns/1ps
`include "rdt_consts.vh"
// Free-running divider giving a one-cycle enable each LAST+1 input pulses
module rdt_divider #(
	parameter W = 8
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire en_i,
	input wire [W-1:0] last_i,
	output reg tick_o
);
	reg [W-1:0] cnt_q;

	// Count enable pulses, wrap at last value
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= {W{1'b0}};
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (en_i) begin
				if (cnt_q >= last_i) begin
					cnt_q <= {W{1'b0}};
					tick_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

/* File: logic/rdt_timer.v */
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "rdt_consts.vh"
// Behaviour
// [RQ1] Four selectable internal count sources
// [RQ2] Decrement per source pulse, reload on underflow
// [RQ3] Underflow rate is source over n+1
// [RQ4] Run bit starts and stops counting
// [RQ5] Interrupt request on every underflow
// [RQ6] Input pin is port or gate
// [RQ7] Output pin is port or pulse
// [RQ8] Count register read returns live counter
// [RQ9] Write while stopped loads reload and counter
// [RQ10] Write while running loads reload only; the counter is also loaded until the first source pulse is counted
// [RQ11] Gate level also qualifies counting
// [RQ12] Pulse output toggles on each underflow
// [RQ13] Pulse output low while run bit clear
// [RQ14] Counter and reload are sixteen bits
// [RQ15] Two-bit mode field selects timer mode
// [RQ16] Gate synchronised, polarity selectable
module rdt_timer (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire timer_gate_pin_i,
	input wire port_out_i,
	output reg timer_pulse_pin_o,
	output reg gate_port_level_o,
	output reg irq_o
);
	reg [15:0] reload_q;
	reg [15:0] count_q;
	reg run_q;
	reg [`RDT_MODE_W-1:0] mode_q;
	reg [7:0] presc_q;
	reg stat_q;
	reg mask_q;
	reg pulse_q;
	reg started_q;
	reg ack_q;
	reg [2:0] gate_sync_q;
	reg gate_lvl_q;
	reg [9:0] sub_cnt_q;
	reg sub_pre_q;
	reg src_tick;
	wire div8_tick;
	wire prog_tick;
	wire sub_tick;
	wire [1:0] src_sel;
	wire timer_mode;
	wire gate_ok;
	wire counting;
	wire underflow;
	wire bus_req;
	wire wr_acc;
	wire rd_acc;
	wire wr_count;

	assign src_sel = mode_q[`RDT_MODE_SRC_HI:`RDT_MODE_SRC_LO];
	assign timer_mode = (mode_q[`RDT_MODE_HI:`RDT_MODE_LO] == `RDT_MODE_TIMER); // RQ15
	assign bus_req = avs_read_i | avs_write_i;
	// Accept on the second cycle; waitrequest drops for one cycle
	assign wr_acc = avs_write_i & ack_q;
	assign rd_acc = avs_read_i & ack_q;
	assign wr_count = wr_acc && (avs_address_i == `RDT_OFF_COUNT) && (&avs_byteenable_i[1:0]);

	// Fixed divide-by-eight of the core clock
	rdt_divider #(.W(3)) u_div8 (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(1'b1),
		.last_i(`RDT_DIV8_LAST),
		.tick_o(div8_tick)
	);

	// Programmable even divide: 2*(presc+1)
	rdt_divider #(.W(9)) u_div_prog (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(1'b1),
		.last_i({presc_q, 1'b1}),
		.tick_o(prog_tick)
	);

	// Subclock stand-in divided by 32; no real subclock pin in this block
	rdt_divider #(.W(5)) u_div_sub (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.en_i(sub_pre_q),
		.last_i(`RDT_SUB_LAST),
		.tick_o(sub_tick)
	);

	// Prescale core clock toward a slow subclock rate
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sub_cnt_q <= 10'h000;
			sub_pre_q <= 1'b0;
		end else begin
			sub_pre_q <= (sub_cnt_q == `RDT_SUB_DIV);
			if (sub_cnt_q == `RDT_SUB_DIV)
				sub_cnt_q <= 10'h000;
			else
				sub_cnt_q <= sub_cnt_q + 10'h001;
		end
	end

	// Count source mux
	always @* begin
		case (src_sel)
			`RDT_SRC_UNDIV: src_tick = 1'b1; // RQ1
			`RDT_SRC_DIV8: src_tick = div8_tick; // RQ1
			`RDT_SRC_PROG: src_tick = prog_tick; // RQ1
			`RDT_SRC_SUB: src_tick = sub_tick; // RQ1
			default: src_tick = 1'b0;
		endcase
	end

	// Three-stage gate synchroniser; level changes when stages 2 and 3 agree
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gate_sync_q <= 3'h0;
			gate_lvl_q <= 1'b0;
		end else begin
			gate_sync_q <= {gate_sync_q[1:0], timer_gate_pin_i}; // RQ16
			if (gate_sync_q[1] == gate_sync_q[2])
				gate_lvl_q <= gate_sync_q[2]; // RQ16
		end
	end

	// Gate optional; polarity bit set means active low
	assign gate_ok = !mode_q[`RDT_MODE_GATE] ||
		(gate_lvl_q ^ mode_q[`RDT_MODE_GPOL]); // RQ11 RQ16
	assign counting = run_q & timer_mode & gate_ok; // RQ4 RQ11
	assign underflow = counting & src_tick & (count_q == 16'h0000); // RQ3

	// Counter and reload path
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reload_q <= `RDT_RST_COUNT;
			count_q <= `RDT_RST_COUNT;
			started_q <= 1'b0;
		end else begin
			if (!run_q)
				started_q <= 1'b0;
			else if (counting && src_tick)
				started_q <= 1'b1;
			if (counting && src_tick) begin
				if (underflow)
					count_q <= reload_q; // RQ2
				else
					count_q <= count_q - 16'h0001; // RQ2 RQ14
			end
			if (wr_count) begin
				reload_q <= avs_writedata_i[15:0]; // RQ10
				if (!started_q && !(counting && src_tick))
					count_q <= avs_writedata_i[15:0]; // RQ9
			end
		end
	end

	// Software registers and bus handshake
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_q <= 1'b0;
			mode_q <= `RDT_RST_MODE;
			presc_q <= `RDT_RST_PRESC;
			mask_q <= 1'b0;
			ack_q <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			ack_q <= bus_req & !ack_q;
			avs_waitrequest_o <= !(bus_req & !ack_q);
			if (wr_acc && avs_byteenable_i[0]) begin
				case (avs_address_i)
					`RDT_OFF_RUN: run_q <= avs_writedata_i[0]; // RQ4
					`RDT_OFF_MODE: mode_q <= avs_writedata_i[`RDT_MODE_W-1:0]; // RQ15
					`RDT_OFF_PRESC: presc_q <= avs_writedata_i[7:0];
					`RDT_OFF_MASK: mask_q <= avs_writedata_i[0];
					default: ;
				endcase
			end
			if (bus_req & !ack_q) begin
				case (avs_address_i)
					`RDT_OFF_COUNT: avs_readdata_o <= {16'h0000, count_q}; // RQ8
					`RDT_OFF_RUN: avs_readdata_o <= {31'h00000000, run_q};
					`RDT_OFF_MODE: avs_readdata_o <= {24'h000000, mode_q};
					`RDT_OFF_PRESC: avs_readdata_o <= {24'h000000, presc_q};
					`RDT_OFF_STAT: avs_readdata_o <= {31'h00000000, stat_q};
					`RDT_OFF_MASK: avs_readdata_o <= {31'h00000000, mask_q};
					default: avs_readdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Sticky underflow flag; set beats the clear-on-read
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_q <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			if (underflow)
				stat_q <= 1'b1; // RQ5
			else if (rd_acc && avs_address_i == `RDT_OFF_STAT)
				stat_q <= 1'b0;
			irq_o <= (stat_q | underflow) & mask_q; // RQ5
		end
	end

	// Pulse output and port pin routing
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pulse_q <= 1'b0;
			timer_pulse_pin_o <= 1'b0;
			gate_port_level_o <= 1'b0;
		end else begin
			if (!run_q)
				pulse_q <= 1'b0; // RQ13
			else if (underflow)
				pulse_q <= !pulse_q; // RQ12
			if (mode_q[`RDT_MODE_PULSE])
				timer_pulse_pin_o <= run_q & (underflow ? !pulse_q : pulse_q); // RQ7 RQ13
			else
				timer_pulse_pin_o <= port_out_i; // RQ7
			// Pin seen as port data when gating is off
			gate_port_level_o <= mode_q[`RDT_MODE_GATE] ? 1'b0 : gate_lvl_q; // RQ6
		end
	end
endmodule

/* File: bench/rdt_timer_sva.sv */
`timescale 1ns/1ps
module rdt_timer_sva (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	input wire timer_gate_pin_i,
	input wire port_out_i,
	input wire timer_pulse_pin_o,
	input wire gate_port_level_o,
	input wire irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic live_q, run_q, mask_q;
	logic [7:0] mode_q;
	wire wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	wire rd_ok = avs_read_i && !avs_waitrequest_o;
	// Shadow of the control bits, so rules can be judged from the ports alone
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{live_q, run_q, mask_q, mode_q} <= 11'h000;
		end else begin
			live_q <= 1'b1;
			if (wr_ok && avs_address_i == 4'h1) run_q <= avs_writedata_i[0];
			if (wr_ok && avs_address_i == 4'h2) mode_q <= avs_writedata_i[7:0];
			if (wr_ok && avs_address_i == 4'h5) mask_q <= avs_writedata_i[0];
		end
	end
	chk_wait_one: assert property (live_q && (avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer after one wait");
	chk_wait_high: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer longer than one cycle");
	chk_miss_zero: assert property (rd_ok && avs_address_i > 4'h5 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_run_read: assert property (rd_ok && avs_address_i == 4'h1
		|-> avs_readdata_o == {31'h0, run_q}) else $error("run bit read wrong");
	chk_mode_read: assert property (rd_ok && avs_address_i == 4'h2
		|-> avs_readdata_o == {24'h0, mode_q}) else $error("mode read wrong");
	chk_pulse_low: assert property (live_q && mode_q[2] && !run_q ##1 mode_q[2] && !run_q
		|-> !timer_pulse_pin_o) else $error("pulse pin high while stopped");
	chk_port_pass: assert property (live_q && !mode_q[2] ##1 !mode_q[2] && $stable(port_out_i)
		|-> timer_pulse_pin_o == port_out_i) else $error("port level not passed");
	chk_gate_port: assert property ((!mode_q[3] && $stable(timer_gate_pin_i))[*5]
		|-> gate_port_level_o == timer_gate_pin_i) else $error("port input level wrong");
	chk_irq_masked: assert property (!mask_q ##1 !mask_q |-> !irq_o)
		else $error("masked interrupt raised");
	cover property ($rose(irq_o));
	cover property (mode_q[2] && $changed(timer_pulse_pin_o));
	cover property (rd_ok && avs_address_i == 4'h4);
endmodule
bind rdt_timer rdt_timer_sva u_sva (.core_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.timer_gate_pin_i, .port_out_i, .timer_pulse_pin_o, .gate_port_level_o, .irq_o);

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic core_clk_i, arst_n_i, avs_read_i, avs_write_i, timer_gate_pin_i, port_out_i;
	logic [3:0] avs_address_i, avs_byteenable_i;
	logic [31:0] avs_writedata_i, q, r;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, timer_pulse_pin_o, gate_port_level_o, irq_o;
	int errors = 0, n_checks = 0, cyc = 0, n, m, p, s;
	rdt_timer u_rdt_timer (.core_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .timer_gate_pin_i, .port_out_i, .timer_pulse_pin_o,
		.gate_port_level_o, .irq_o);
	initial begin
		core_clk_i = 0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Cut a hang short; every test ends well before this
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			finish_test;
		end
	end
	task finish_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One transfer: drive after a rising edge, hold until waitrequest is seen low at an edge
	task bus(input [3:0] a, input w, input [31:0] d, output [31:0] rq);
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		@(posedge core_clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
		rq = avs_readdata_o;
		{avs_write_i, avs_read_i} <= 2'b00;
		@(negedge core_clk_i);
	endtask
	// Cycles between two pulse pin toggles; the first period is skipped
	task per(output int c);
		logic v;
		v = timer_pulse_pin_o;
		@(negedge core_clk_i);
		while (timer_pulse_pin_o === v) @(negedge core_clk_i);
		v = timer_pulse_pin_o;
		c = 0;
		while (timer_pulse_pin_o === v) begin
			@(negedge core_clk_i);
			c++;
		end
		@(posedge core_clk_i);
	endtask
	function int exp_per(int src, int rl, int pr);
		return (rl + 1) * (src == 0 ? 1 : src == 1 ? 8 : 2 * (pr + 1));
	endfunction
	initial begin
		{avs_read_i, avs_write_i, timer_gate_pin_i, port_out_i} = 4'h0;
		avs_address_i = 4'h0;
		avs_byteenable_i = 4'hF;
		avs_writedata_i = 32'h0;
		arst_n_i = 0;
		n = $urandom(41454);
		repeat (12) @(posedge core_clk_i);
		arst_n_i <= 1;
		@(posedge core_clk_i);
		bus(4'h0, 0, 0, q); chk(q, 32'h0000FFFF);
		bus(4'h9, 0, 0, q); chk(q, 32'h0);
		bus(4'h5, 1, 1, q);
		// Undivided, divide-by-eight and programmable sources with a random small reload and prescale
		for (s = 0; s < 3; s++) begin
			n = $urandom % 4;
			p = $urandom % 4;
			bus(4'h1, 1, 0, q);
			bus(4'h3, 1, p, q);
			bus(4'h0, 1, n, q);
			bus(4'h0, 0, 0, q); chk(q, n);
			bus(4'h2, 1, {s[1:0], 6'h04}, q);
			bus(4'h1, 1, 1, q);
			per(m); chk(m, exp_per(s, n, p));
			chk(irq_o, 1);
		end
		// Running write lands in reload only; read shows live count
		m = 2 + $urandom % 5;
		bus(4'h1, 1, 0, q);
		bus(4'h2, 1, 8'h04, q);
		bus(4'h0, 1, 16'h0400, q);
		bus(4'h1, 1, 1, q);
		bus(4'h0, 1, m, q);
		bus(4'h0, 0, 0, q); chk(q > 16 && q < 32'h400, 1);
		per(n); chk(n, m + 1);
		bus(4'h1, 1, 0, q);
		// Pin follows the run bit one registered cycle later
		@(negedge core_clk_i);
		chk(timer_pulse_pin_o, 0);
		bus(4'h4, 0, 0, q); chk(q, 1);
		@(negedge core_clk_i);
		chk(irq_o, 0);
		bus(4'h2, 1, 0, q);
		@(posedge core_clk_i);
		port_out_i <= 1;
		repeat (3) @(negedge core_clk_i);
		chk(timer_pulse_pin_o, 1);
		// Gate blocks, then admits counting
		bus(4'h2, 1, 8'h08, q);
		bus(4'h0, 1, 16'h0100, q);
		bus(4'h1, 1, 1, q);
		repeat (8) @(posedge core_clk_i);
		bus(4'h0, 0, 0, q); chk(q, 16'h0100);
		chk(gate_port_level_o, 0);
		@(posedge core_clk_i);
		timer_gate_pin_i <= 1;
		repeat (10) @(posedge core_clk_i);
		bus(4'h0, 0, 0, q); chk(q < 32'h100, 1);
		// Inverted gate and the other modes must hold the count
		for (s = 0; s < 4; s++) begin
			bus(4'h2, 1, s ? s : 8'h18, q);
			repeat (6) @(posedge core_clk_i);
			bus(4'h0, 0, 0, r);
			bus(4'h0, 0, 0, q); chk(q, r);
		end
		finish_test;
	end
endmodule
